// ### design/ocalu_pkg.sv
package ocalu_pkg;
   localparam logic [4:0] REG_STATUS_LOW = 5'h10;
   localparam logic [4:0] REG_STATUS_HIGH = 5'h11;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam int FLAG_S = 7;
   localparam int FLAG_Z = 6;
   localparam int FLAG_AC = 4;
   localparam int FLAG_PV = 2;
   localparam int FLAG_CY = 0;
   localparam logic [2:0] PAIR_VP = 3'h4;
   localparam logic [2:0] PAIR_UP = 3'h5;
   localparam logic [2:0] PAIR_DE = 3'h6;
   localparam logic [2:0] PAIR_HL = 3'h7;
   localparam logic [3:0] IDX_A = 4'h1;
   localparam logic [3:0] IDX_B = 4'h3;
   localparam logic [15:0] SADDR_LO = 16'hfe20;
   localparam logic [15:0] SADDR_HI = 16'hff1f;
   localparam logic [15:0] ABS_HI = 16'hfdff;
   localparam logic [15:0] TBL_LO = 16'hfe00;
   localparam logic [15:0] TBL_HI = 16'hfeff;
   localparam logic [15:0] CALLF_LO = 16'h0800;
   localparam logic [15:0] CALLT_LO = 16'h0040;
   localparam logic [15:0] CALLT_HI = 16'h007e;
   localparam logic [7:0] SFR_STANDBY_OFS = 8'hf0;
   localparam logic [7:0] SFR_WATCHDOG_OFS = 8'hf1;

   typedef enum logic [3:0] {
      OP_MOV, OP_XCH, OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW,
      OP_AND, OP_OR, OP_XOR, OP_CMP
   } ocalu_op_type;

   typedef enum logic [2:0] {
      F_R, F_R1, F_RP, F_RP1, F_RP2, F_IMM, F_EXT, F_STATUS_WORD_LOW
   } ocalu_fld_type;

   typedef enum logic [3:0] {
      AM_SADDR, AM_SADDRP, AM_ABS, AM_ABS_BYTE, AM_TBL,
      AM_CALLF, AM_CALLT, AM_REL, AM_IND
   } ocalu_am_type;

   typedef enum logic [2:0] {
      I_REG, I_PINC, I_PDEC, I_IDXA, I_IDXB, I_VPP, I_DISP, I_WORD
   } ocalu_ind_type;

   typedef struct packed {
      ocalu_op_type op;
      logic wd;
      ocalu_fld_type dk;
      logic [3:0] df;
      ocalu_fld_type sk;
      logic [3:0] sf;
      logic [15:0] imm;
      logic [15:0] mem_d;
      logic [15:0] mem_s;
      logic sfr;
      logic sfr_w16;
      logic [7:0] sfr_ofs;
   } ocalu_req_type;

   typedef struct packed {
      ocalu_am_type am;
      ocalu_ind_type im;
      logic [2:0] bs;
      logic wd;
      logic [15:0] val;
      logic [15:0] pc;
      logic [15:0] sp;
      logic [2:0] bitn;
   } ocalu_ag_type;
endpackage

// ### design/ocalu_core.sv
// Operation
// - sixteen byte registers as eight pairs; restricted byte field reaches first eight
// - restricted pair field selects only the four pointer pairs
// - both general pair fields name same pairs with different encodings
// - short direct byte operand addresses only FE20H to FF1FH
// - short direct word operand spans FE20H to FF1EH, even only
// - absolute operand up to FDFFH; byte transfers reach FFFFH
// - table shift accepts only addresses FE00H to FEFFH
// - fixed area call targets 800H to FFFH
// - call table entry is even address 40H to 7EH
// - relative displacement -128 to +127 from next instruction
// - immediates are 16 bits word, 8 bits byte, 3 bits counts
// - pair five only on system stack list, status word only user
// - indirect modes: register, post inc/dec, based, displaced, indexed
// - word access to special register only if it allows 16 bits
// - immediate byte store to standby or watchdog is dedicated instruction
// - byte add writes sum, carry, sign, zero, aux carry, overflow
// - subtract and subtract with borrow set borrow and overflow
// - logical ops set sign, zero, parity; keep aux carry and carry
// - compare subtracts without result, sets all five flags
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module ocalu_core (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [4:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   output logic [7:0] bus_rdata_o,
   input wire logic op_valid_i,
   input wire ocalu_pkg::ocalu_req_type op_i,
   output logic ex_done_o,
   output logic [15:0] ex_res_o,
   output logic ex_res_we_o,
   output logic ex_err_o,
   output logic ex_dedic_o,
   output logic [7:0] status_o,
   input wire logic ag_valid_i,
   input wire ocalu_pkg::ocalu_ag_type ag_i,
   output logic ag_done_o,
   output logic [15:0] ag_addr_o,
   output logic ag_err_o,
   output logic [7:0] bit_mask_o,
   input wire logic [8:0] plst_i,
   input wire logic plst_user_i,
   output logic plst_ok_o
);
   logic [7:0] regs_q [16];
   logic [7:0] regs_d [16];
   logic [7:0] psw_q, psw_d, status_word_high_q, status_word_high_d;
   logic [7:0] rdata_q, rdata_d;
   logic done_q, done_d, we_q, we_d, err_q, err_d;
   logic dedic_q, dedic_d;
   logic [15:0] res_q, res_d;
   logic agd_q, agd_d, age_q, age_d, plok_q, plok_d;
   logic [15:0] aga_q, aga_d;
   logic [7:0] bm_q, bm_d;
   ocalu_pkg::ocalu_ag_type ag_last_q;
   logic [15:0] a, b, bx, res;
   logic [8:0] s9;
   logic [16:0] s17;
   logic [4:0] n5;
   logic is_sub, is_log, is_ari, cin, carry, ovf, msb;
   logic refuse_c, dedic_c;
   logic [15:0] base, addr, step;
   logic aerr;

   function automatic logic [3:0] byte_idx(ocalu_pkg::ocalu_fld_type k,
                                           logic [3:0] f);
      byte_idx = (k == ocalu_pkg::F_R1) ? {1'b0, f[2:0]} : f;
   endfunction

   function automatic logic [2:0] ptr_pair(logic [1:0] f);
      logic [2:0] p;
      p = ocalu_pkg::PAIR_UP;
      if (f == 2'h0) p = ocalu_pkg::PAIR_DE;
      if (f == 2'h1) p = ocalu_pkg::PAIR_HL;
      if (f == 2'h2) p = ocalu_pkg::PAIR_VP;
      return p;
   endfunction

   function automatic logic [2:0] pair_idx(ocalu_pkg::ocalu_fld_type k,
                                           logic [3:0] f);
      logic [2:0] p;
      p = f[2:0];
      if (k == ocalu_pkg::F_RP) p = {f[0], f[2:1]};
      if (k == ocalu_pkg::F_RP2) p = ptr_pair(f[1:0]);
      return p;
   endfunction

   function automatic logic [15:0] pr(logic [2:0] p);
      return {regs_q[{p, 1'b1}], regs_q[{p, 1'b0}]};
   endfunction

   function automatic logic [15:0] rd_opnd(ocalu_pkg::ocalu_fld_type k,
                                           logic [3:0] f, logic wd,
                                           logic [15:0] imm,
                                           logic [15:0] mem);
      logic [15:0] v;
      v = {8'h00, regs_q[byte_idx(k, f)]};
      if (wd) v = pr(pair_idx(k, f));
      if (k == ocalu_pkg::F_IMM) v = wd ? imm : {8'h00, imm[7:0]};
      if (k == ocalu_pkg::F_EXT) v = wd ? mem : {8'h00, mem[7:0]};
      if (k == ocalu_pkg::F_STATUS_WORD_LOW) v = {8'h00, psw_q};
      return v;
   endfunction

   task automatic put(ocalu_pkg::ocalu_fld_type k, logic [3:0] f,
                      logic wd, logic [15:0] v);
      logic [3:0] bi;
      logic [2:0] pi;
      bi = byte_idx(k, f);
      pi = pair_idx(k, f);
      if (k == ocalu_pkg::F_STATUS_WORD_LOW) begin
         psw_d = v[7:0];
      end else if (k == ocalu_pkg::F_EXT) begin
         res_d = v;
         we_d = 1'b1;
      end else if (wd) begin
         regs_d[{pi, 1'b1}] = v[15:8];
         regs_d[{pi, 1'b0}] = v[7:0];
      end else begin
         regs_d[bi] = v[7:0];
      end
   endtask

   // operand fetch and arithmetic
   always_comb begin
      a = rd_opnd(op_i.dk, op_i.df, op_i.wd, op_i.imm, op_i.mem_d);
      b = rd_opnd(op_i.sk, op_i.sf, op_i.wd, op_i.imm, op_i.mem_s);
      is_sub = op_i.op inside {ocalu_pkg::OP_SUB, ocalu_pkg::OP_SUBTRACT_WITH_BORROW,
                               ocalu_pkg::OP_CMP};
      is_log = op_i.op inside {ocalu_pkg::OP_AND, ocalu_pkg::OP_OR,
                               ocalu_pkg::OP_XOR};
      is_ari = is_sub || op_i.op inside {ocalu_pkg::OP_ADD,
                                         ocalu_pkg::OP_ADD_WITH_CARRY};
      cin = psw_q[ocalu_pkg::FLAG_CY] &&
            op_i.op inside {ocalu_pkg::OP_ADD_WITH_CARRY, ocalu_pkg::OP_SUBTRACT_WITH_BORROW};
      bx = is_sub ? ~b : b;
      s9 = {1'b0, a[7:0]} + {1'b0, bx[7:0]} + {8'h00, is_sub ^ cin};
      s17 = {1'b0, a} + {1'b0, bx} + {16'h0000, is_sub ^ cin};
      n5 = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, is_sub ^ cin};
      res = op_i.wd ? s17[15:0] : {8'h00, s9[7:0]};
      carry = (op_i.wd ? s17[16] : s9[8]) ^ is_sub;
      if (op_i.op == ocalu_pkg::OP_AND) res = a & b;
      if (op_i.op == ocalu_pkg::OP_OR) res = a | b;
      if (op_i.op == ocalu_pkg::OP_XOR) res = a ^ b;
      if (op_i.op inside {ocalu_pkg::OP_MOV, ocalu_pkg::OP_XCH}) res = b;
      msb = op_i.wd ? res[15] : res[7];
      ovf = op_i.wd ? (a[15] == bx[15]) && (res[15] != a[15])
                    : (a[7] == bx[7]) && (res[7] != a[7]);
   end

   assign refuse_c = op_i.wd && op_i.sfr && !op_i.sfr_w16 &&
                     (op_i.dk == ocalu_pkg::F_EXT ||
                      op_i.sk == ocalu_pkg::F_EXT);
   assign dedic_c = op_i.op == ocalu_pkg::OP_MOV && !op_i.wd &&
                    op_i.sk == ocalu_pkg::F_IMM &&
                    op_i.dk == ocalu_pkg::F_EXT && op_i.sfr &&
                    (op_i.sfr_ofs == ocalu_pkg::SFR_STANDBY_OFS ||
                     op_i.sfr_ofs == ocalu_pkg::SFR_WATCHDOG_OFS);

   // address generation
   always_comb begin
      step = ag_i.wd ? 16'h0002 : 16'h0001;
      base = ag_i.bs[2] ? ag_i.sp : pr(ptr_pair(ag_i.bs[1:0]));
      addr = ag_i.val;
      aerr = 1'b0;
      unique case (ag_i.am)
         ocalu_pkg::AM_SADDR: begin
            addr = ocalu_pkg::SADDR_LO + {8'h00, ag_i.val[7:0]};
         end
         ocalu_pkg::AM_SADDRP: begin
            addr = ocalu_pkg::SADDR_LO + {8'h00, ag_i.val[7:0]};
            aerr = ag_i.val[0];
         end
         ocalu_pkg::AM_ABS: begin
            aerr = ag_i.val > ocalu_pkg::ABS_HI;
         end
         ocalu_pkg::AM_ABS_BYTE: begin
            aerr = 1'b0;
         end
         ocalu_pkg::AM_TBL: begin
            aerr = ag_i.val < ocalu_pkg::TBL_LO ||
                   ag_i.val > ocalu_pkg::TBL_HI;
         end
         ocalu_pkg::AM_CALLF: begin
            addr = ocalu_pkg::CALLF_LO | {5'h00, ag_i.val[10:0]};
         end
         ocalu_pkg::AM_CALLT: begin
            addr = ocalu_pkg::CALLT_LO + {10'h000, ag_i.val[4:0], 1'b0};
         end
         ocalu_pkg::AM_REL: begin
            addr = ag_i.pc + {{8{ag_i.val[7]}}, ag_i.val[7:0]};
         end
         ocalu_pkg::AM_IND: begin
            unique case (ag_i.im)
               ocalu_pkg::I_REG: addr = base;
               ocalu_pkg::I_PINC: addr = base;
               ocalu_pkg::I_PDEC: addr = base;
               ocalu_pkg::I_IDXA: addr = base + {8'h00, regs_q[ocalu_pkg::IDX_A]};
               ocalu_pkg::I_IDXB: addr = base + {8'h00, regs_q[ocalu_pkg::IDX_B]};
               ocalu_pkg::I_VPP: begin
                  addr = pr(ocalu_pkg::PAIR_VP) +
                         pr(ag_i.bs[0] ? ocalu_pkg::PAIR_HL : ocalu_pkg::PAIR_DE);
               end
               ocalu_pkg::I_DISP: addr = base + {8'h00, ag_i.val[7:0]};
               ocalu_pkg::I_WORD: begin
                  addr = ag_i.val + pr(ptr_pair(ag_i.bs[1:0]));
                  if (ag_i.bs[1:0] == 2'h0) begin
                     addr = ag_i.val + {8'h00, regs_q[ocalu_pkg::IDX_A]};
                  end
                  if (ag_i.bs[1:0] == 2'h1) begin
                     addr = ag_i.val + {8'h00, regs_q[ocalu_pkg::IDX_B]};
                  end
               end
            endcase
            aerr = ag_i.bs[2] && ag_i.im inside {ocalu_pkg::I_PINC,
                                                 ocalu_pkg::I_PDEC};
         end
      endcase
      if (ag_i.wd && addr[0] && ag_i.am != ocalu_pkg::AM_CALLT) aerr = 1'b1;
   end

   // next state of registers, flags and outputs
   always_comb begin
      regs_d = regs_q;
      psw_d = psw_q;
      status_word_high_d = status_word_high_q;
      res_d = res_q;
      we_d = 1'b0;
      err_d = 1'b0;
      dedic_d = 1'b0;
      done_d = op_valid_i;
      rdata_d = 8'h00;
      if (bus_rd_i) begin
         if (!bus_addr_i[4]) rdata_d = regs_q[bus_addr_i[3:0]];
         if (bus_addr_i == ocalu_pkg::REG_STATUS_LOW) rdata_d = psw_q;
         if (bus_addr_i == ocalu_pkg::REG_STATUS_HIGH) rdata_d = status_word_high_q;
      end
      if (bus_wr_i) begin
         if (!bus_addr_i[4]) regs_d[bus_addr_i[3:0]] = bus_wdata_i;
         if (bus_addr_i == ocalu_pkg::REG_STATUS_LOW) psw_d = bus_wdata_i;
         if (bus_addr_i == ocalu_pkg::REG_STATUS_HIGH) status_word_high_d = bus_wdata_i;
      end
      agd_d = ag_valid_i;
      aga_d = ag_valid_i ? addr : aga_q;
      age_d = ag_valid_i && aerr;
      bm_d = ag_valid_i ? 8'h01 << ag_i.bitn : bm_q;
      if (ag_valid_i && !aerr && ag_i.am == ocalu_pkg::AM_IND) begin
         if (ag_i.im == ocalu_pkg::I_PINC) begin
            put(ocalu_pkg::F_RP2, {2'h0, ag_i.bs[1:0]}, 1'b1, base + step);
         end
         if (ag_i.im == ocalu_pkg::I_PDEC) begin
            put(ocalu_pkg::F_RP2, {2'h0, ag_i.bs[1:0]}, 1'b1, base - step);
         end
      end
      if (op_valid_i && (refuse_c || dedic_c)) begin
         err_d = refuse_c;
         dedic_d = dedic_c && !refuse_c;
      end else if (op_valid_i) begin
         if (is_ari) begin
            psw_d[ocalu_pkg::FLAG_S] = msb;
            psw_d[ocalu_pkg::FLAG_Z] = op_i.wd ? res == 16'h0000
                                               : res[7:0] == 8'h00;
            psw_d[ocalu_pkg::FLAG_AC] = n5[4] ^ is_sub;
            psw_d[ocalu_pkg::FLAG_PV] = ovf;
            psw_d[ocalu_pkg::FLAG_CY] = carry;
         end
         if (is_log) begin
            psw_d[ocalu_pkg::FLAG_S] = msb;
            psw_d[ocalu_pkg::FLAG_Z] = op_i.wd ? res == 16'h0000
                                               : res[7:0] == 8'h00;
            psw_d[ocalu_pkg::FLAG_PV] = op_i.wd ? ~^res : ~^res[7:0];
         end
         if (op_i.op != ocalu_pkg::OP_CMP) begin
            put(op_i.dk, op_i.df, op_i.wd, res);
         end
         if (op_i.op == ocalu_pkg::OP_XCH) begin
            put(op_i.sk, op_i.sf, op_i.wd, a);
         end
      end
   end

   assign plok_d = !(plst_user_i ? plst_i[5] : plst_i[8]);

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 16; i++) begin
            regs_q[i] <= ocalu_pkg::RST_REG;
         end
         psw_q <= ocalu_pkg::RST_STATUS;
         status_word_high_q <= ocalu_pkg::RST_STATUS;
         rdata_q <= 8'h00;
         done_q <= 1'b0;
         we_q <= 1'b0;
         err_q <= 1'b0;
         dedic_q <= 1'b0;
         res_q <= 16'h0000;
         agd_q <= 1'b0;
         age_q <= 1'b0;
         aga_q <= 16'h0000;
         bm_q <= 8'h00;
         plok_q <= 1'b1;
         ag_last_q <= '0;
      end else begin
         regs_q <= regs_d;
         psw_q <= psw_d;
         status_word_high_q <= status_word_high_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
         we_q <= we_d;
         err_q <= err_d;
         dedic_q <= dedic_d;
         res_q <= res_d;
         agd_q <= agd_d;
         age_q <= age_d;
         aga_q <= aga_d;
         bm_q <= bm_d;
         plok_q <= plok_d;
         ag_last_q <= ag_i;
      end
   end

   assign bus_rdata_o = rdata_q;
   assign ex_done_o = done_q;
   assign ex_res_o = res_q;
   assign ex_res_we_o = we_q;
   assign ex_err_o = err_q;
   assign ex_dedic_o = dedic_q;
   assign status_o = psw_q;
   assign ag_done_o = agd_q;
   assign ag_addr_o = aga_q;
   assign ag_err_o = age_q;
   assign bit_mask_o = bm_q;
   assign plst_ok_o = plok_q;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   AST_SADDR_WIN: assert property (
      ag_valid_i && ag_i.am == ocalu_pkg::AM_SADDR |=>
      ag_addr_o >= ocalu_pkg::SADDR_LO && ag_addr_o <= ocalu_pkg::SADDR_HI)
      else $error("short direct address outside window");
   AST_SADDRP_ODD: assert property (
      ag_valid_i && ag_i.am == ocalu_pkg::AM_SADDRP && ag_i.val[0] |=>
      ag_err_o && ag_done_o)
      else $error("odd short word address not flagged");
   AST_ABS_HIGH: assert property (
      ag_valid_i && ag_i.am == ocalu_pkg::AM_ABS &&
      ag_i.val > ocalu_pkg::ABS_HI |=> ag_err_o)
      else $error("absolute address above ceiling accepted");
   AST_TBL_OK: assert property (
      ag_valid_i && ag_i.am == ocalu_pkg::AM_TBL && !ag_i.val[0] &&
      ag_i.val[15:8] == ocalu_pkg::TBL_LO[15:8] |=> !ag_err_o)
      else $error("legal table address refused");
   AST_CALLF_AREA: assert property (
      ag_valid_i && ag_i.am == ocalu_pkg::AM_CALLF |=>
      ag_addr_o[15:11] == 5'h01)
      else $error("fixed call target outside area");
   AST_CALLT_TBL: assert property (
      ag_valid_i && ag_i.am == ocalu_pkg::AM_CALLT |=>
      ag_addr_o >= ocalu_pkg::CALLT_LO &&
      ag_addr_o <= ocalu_pkg::CALLT_HI && !ag_addr_o[0])
      else $error("call table entry out of range");
   AST_REL_TGT: assert property (
      ag_done_o && ag_last_q.am == ocalu_pkg::AM_REL |->
      ag_addr_o == ag_last_q.pc + {{8{ag_last_q.val[7]}}, ag_last_q.val[7:0]})
      else $error("relative target wrong");
   AST_LOGIC_KEEP: assert property (
      op_valid_i && is_log && !refuse_c && op_i.dk != ocalu_pkg::F_STATUS_WORD_LOW &&
      !bus_wr_i |=> (status_o & 8'h11) == ($past(status_o) & 8'h11))
      else $error("logical op changed carry flags");
   AST_MOV_KEEP: assert property (
      op_valid_i && op_i.op inside {ocalu_pkg::OP_MOV, ocalu_pkg::OP_XCH} &&
      op_i.dk != ocalu_pkg::F_STATUS_WORD_LOW && op_i.sk != ocalu_pkg::F_STATUS_WORD_LOW &&
      !bus_wr_i |=> status_o == $past(status_o))
      else $error("transfer changed flags");
   AST_CMP_NOWR: assert property (
      op_valid_i && op_i.op == ocalu_pkg::OP_CMP |=> ex_done_o && !ex_res_we_o)
      else $error("compare wrote a result");
   AST_DEDIC: assert property (
      op_valid_i && dedic_c && !refuse_c |=> ex_dedic_o && !ex_res_we_o ##1
      (!ex_dedic_o || $past(op_valid_i)))
      else $error("dedicated store not signalled");

   COV_ADD_CARRY: cover property (op_valid_i && op_i.op == ocalu_pkg::OP_ADD && carry);
   COV_WORD_SUB: cover property (op_valid_i && op_i.wd && op_i.op == ocalu_pkg::OP_SUB);
   COV_PINC: cover property (ag_valid_i && ag_i.am == ocalu_pkg::AM_IND && ag_i.im == ocalu_pkg::I_PINC);
endmodule

// ### tb/tb_ocalu_core.sv
`timescale 1ns/1ps
module tb_ocalu_core;
   logic sys_clk_i, rst_n_i, bus_wr_i, bus_rd_i, op_valid_i, ag_valid_i, plst_user_i;
   logic [4:0] bus_addr_i;
   logic [7:0] bus_wdata_i;
   logic [8:0] plst_i;
   ocalu_pkg::ocalu_req_type op_i;
   ocalu_pkg::ocalu_ag_type ag_i;
   logic [7:0] bus_rdata_o, status_o, bit_mask_o;
   logic [15:0] ex_res_o, ag_addr_o;
   logic ex_done_o, ex_res_we_o, ex_err_o, ex_dedic_o, ag_done_o, ag_err_o, plst_ok_o;
   int mismatches = 0;
   int samples_checked = 0;

   ocalu_core ocalu_core_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_addr_i(bus_addr_i),
      .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o),
      .op_valid_i(op_valid_i), .op_i(op_i), .ex_done_o(ex_done_o), .ex_res_o(ex_res_o),
      .ex_res_we_o(ex_res_we_o), .ex_err_o(ex_err_o), .ex_dedic_o(ex_dedic_o), .status_o(status_o),
      .ag_valid_i(ag_valid_i), .ag_i(ag_i), .ag_done_o(ag_done_o), .ag_addr_o(ag_addr_o),
      .ag_err_o(ag_err_o), .bit_mask_o(bit_mask_o), .plst_i(plst_i), .plst_user_i(plst_user_i),
      .plst_ok_o(plst_ok_o));

   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic bwr(input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      bus_wr_i <= 1'b1;
      bus_addr_i <= a;
      bus_wdata_i <= d;
      @(posedge sys_clk_i);
      bus_wr_i <= 1'b0;
   endtask

   task automatic brd(input logic [4:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      bus_rd_i <= 1'b1;
      bus_addr_i <= a;
      @(posedge sys_clk_i);
      bus_rd_i <= 1'b0;
      #1 d = bus_rdata_o;
   endtask

   // one execute request; done is judged the cycle after it stands
   task automatic exec(input ocalu_pkg::ocalu_op_type op, input logic wd, input ocalu_pkg::ocalu_fld_type dk,
                       input logic [3:0] df, input logic [15:0] imm, input logic sfr, input logic w16);
      ocalu_pkg::ocalu_req_type r;
      r = '0;
      r.op = op;
      r.wd = wd;
      r.dk = dk;
      r.df = df;
      r.sk = ocalu_pkg::F_IMM;
      r.imm = imm;
      r.sfr = sfr;
      r.sfr_w16 = w16;
      r.sfr_ofs = ocalu_pkg::SFR_STANDBY_OFS;
      @(posedge sys_clk_i);
      op_valid_i <= 1'b1;
      op_i <= r;
      @(posedge sys_clk_i);
      op_valid_i <= 1'b0;
      #1 chk("ex_done", 16'h0001, {15'h0, ex_done_o});
   endtask

   task automatic abyte(input ocalu_pkg::ocalu_op_type op, input logic [7:0] v, input logic [7:0] ea,
                        input logic [7:0] ef);
      logic [7:0] d;
      exec(op, 1'b0, ocalu_pkg::F_R, ocalu_pkg::IDX_A, {8'h00, v}, 1'b0, 1'b0);
      chk("status", {8'h00, ef}, {8'h00, status_o});
      brd(5'h01, d);
      chk("reg_a", {8'h00, ea}, {8'h00, d});
   endtask

   task automatic t_reset;
      logic [7:0] d;
      brd(5'h03, d);
      chk("reset_reg", 16'h0000, {8'h00, d});
      chk("reset_status", 16'h0000, {8'h00, status_o});
      chk("reset_plst", 16'h0001, {15'h0, plst_ok_o});
      brd(5'h12, d);
      chk("unmapped", 16'h0000, {8'h00, d});
   endtask

   task automatic t_arith;
      bwr(5'h01, 8'h7f);
      abyte(ocalu_pkg::OP_ADD, 8'h01, 8'h80, 8'h94);
      abyte(ocalu_pkg::OP_ADD, 8'h80, 8'h00, 8'h45);
      abyte(ocalu_pkg::OP_ADD_WITH_CARRY, 8'h00, 8'h01, 8'h00);
      abyte(ocalu_pkg::OP_SUB, 8'h02, 8'hff, 8'h91);
      abyte(ocalu_pkg::OP_SUBTRACT_WITH_BORROW, 8'h00, 8'hfe, 8'h80);
   endtask

   task automatic t_logic;
      bwr(5'h10, 8'h11);
      abyte(ocalu_pkg::OP_AND, 8'h0f, 8'h0e, 8'h11);
      abyte(ocalu_pkg::OP_OR, 8'h01, 8'h0f, 8'h15);
      abyte(ocalu_pkg::OP_XOR, 8'h0f, 8'h00, 8'h55);
      abyte(ocalu_pkg::OP_CMP, 8'h01, 8'h00, 8'h91);
      abyte(ocalu_pkg::OP_MOV, 8'h5a, 8'h5a, 8'h91);
   endtask

   task automatic t_word;
      logic [7:0] d;
      bwr(5'h00, 8'hff);
      bwr(5'h01, 8'h7f);
      exec(ocalu_pkg::OP_ADD, 1'b1, ocalu_pkg::F_RP, 4'h0, 16'h0001, 1'b0, 1'b0);
      chk("word_status", 16'h0094, {8'h00, status_o});
      brd(5'h01, d);
      chk("word_hi", 16'h0080, {8'h00, d});
      brd(5'h00, d);
      chk("word_lo", 16'h0000, {8'h00, d});
   endtask

   task automatic t_refuse;
      exec(ocalu_pkg::OP_ADD, 1'b1, ocalu_pkg::F_EXT, 4'h0, 16'h1234, 1'b1, 1'b0);
      chk("ex_err", 16'h0001, {15'h0, ex_err_o});
      chk("err_we", 16'h0000, {15'h0, ex_res_we_o});
      chk("err_status", 16'h0094, {8'h00, status_o});
      exec(ocalu_pkg::OP_MOV, 1'b0, ocalu_pkg::F_EXT, 4'h0, 16'h0003, 1'b1, 1'b0);
      chk("ex_dedic", 16'h0001, {15'h0, ex_dedic_o});
      chk("dedic_we", 16'h0000, {15'h0, ex_res_we_o});
      exec(ocalu_pkg::OP_MOV, 1'b0, ocalu_pkg::F_EXT, 4'h0, 16'h00a5, 1'b0, 1'b0);
      chk("ext_we", 16'h0001, {15'h0, ex_res_we_o});
      chk("ext_res", 16'h00a5, ex_res_o);
   endtask

   task automatic t_xchg;
      ocalu_pkg::ocalu_req_type r;
      logic [7:0] d;
      r = '0;
      r.op = ocalu_pkg::OP_XCH;
      r.dk = ocalu_pkg::F_R;
      r.df = ocalu_pkg::IDX_A;
      r.sk = ocalu_pkg::F_R1;
      r.sf = ocalu_pkg::IDX_B;
      bwr(5'h03, 8'h3c);
      @(posedge sys_clk_i);
      op_valid_i <= 1'b1;
      op_i <= r;
      @(posedge sys_clk_i);
      op_valid_i <= 1'b0;
      #1 chk("xch_done", 16'h0001, {15'h0, ex_done_o});
      chk("xch_status", 16'h0094, {8'h00, status_o});
      brd(5'h01, d);
      chk("xch_a", 16'h003c, {8'h00, d});
      brd(5'h03, d);
      chk("xch_b", 16'h0080, {8'h00, d});
   endtask

   task automatic agen(input ocalu_pkg::ocalu_am_type am, input logic wd, input logic [15:0] v,
                       input logic [15:0] ea, input logic ee);
      ocalu_pkg::ocalu_ag_type g;
      g = '0;
      g.am = am;
      g.wd = wd;
      g.val = v;
      g.bitn = 3'h3;
      @(posedge sys_clk_i);
      ag_valid_i <= 1'b1;
      ag_i <= g;
      @(posedge sys_clk_i);
      ag_valid_i <= 1'b0;
      #1 chk("ag_done", 16'h0001, {15'h0, ag_done_o});
      chk("ag_err", {15'h0, ee}, {15'h0, ag_err_o});
      if (!ee) chk("ag_addr", ea, ag_addr_o);
      chk("bit_mask", 16'h0008, {8'h00, bit_mask_o});
   endtask

   task automatic t_addr;
      agen(ocalu_pkg::AM_SADDR, 1'b0, 16'h0005, 16'hfe25, 1'b0);
      agen(ocalu_pkg::AM_SADDR, 1'b0, 16'h00ff, 16'hff1f, 1'b0);
      agen(ocalu_pkg::AM_SADDRP, 1'b1, 16'h00fe, 16'hff1e, 1'b0);
      agen(ocalu_pkg::AM_SADDRP, 1'b1, 16'h0003, 16'h0000, 1'b1);
      agen(ocalu_pkg::AM_ABS, 1'b0, 16'hfdff, 16'hfdff, 1'b0);
      agen(ocalu_pkg::AM_ABS, 1'b0, 16'hfe00, 16'h0000, 1'b1);
      agen(ocalu_pkg::AM_ABS_BYTE, 1'b0, 16'hffff, 16'hffff, 1'b0);
      agen(ocalu_pkg::AM_TBL, 1'b1, 16'hfefe, 16'hfefe, 1'b0);
      agen(ocalu_pkg::AM_TBL, 1'b1, 16'hff00, 16'h0000, 1'b1);
      agen(ocalu_pkg::AM_CALLF, 1'b0, 16'h0123, 16'h0923, 1'b0);
      agen(ocalu_pkg::AM_CALLT, 1'b0, 16'h001f, 16'h007e, 1'b0);
      agen(ocalu_pkg::AM_REL, 1'b0, 16'h0080, 16'hff80, 1'b0);
      agen(ocalu_pkg::AM_IND, 1'b0, 16'h0000, 16'h0000, 1'b0);
   endtask

   task automatic plst(input logic [8:0] l, input logic u, input logic e);
      @(posedge sys_clk_i);
      plst_i <= l;
      plst_user_i <= u;
      @(posedge sys_clk_i);
      #1 chk("plst_ok", {15'h0, e}, {15'h0, plst_ok_o});
   endtask

   task automatic t_plst;
      plst(9'h020, 1'b1, 1'b0);
      plst(9'h020, 1'b0, 1'b1);
      plst(9'h100, 1'b0, 1'b0);
      plst(9'h103, 1'b1, 1'b1);
   endtask

   task automatic summarize;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #20000;
      mismatches++;
      summarize();
   end

   initial begin
      rst_n_i = 1'b0;
      {bus_wr_i, bus_rd_i, op_valid_i, ag_valid_i, plst_user_i} = '0;
      bus_addr_i = '0;
      bus_wdata_i = '0;
      plst_i = '0;
      op_i = '0;
      ag_i = '0;
      repeat (20) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_arith();
      t_logic();
      t_word();
      t_refuse();
      t_xchg();
      t_addr();
      t_plst();
      summarize();
   end
endmodule
